// ### cswc_mem.sv
// External memory model for the chip select bench.
// Assumes the bench tells it whether the addressed device is 8 bits wide.
`default_nettype none
module cswc_mem (
    input wire logic [23:0] ext_addr, // Address bus.
    input wire logic ext_rd_n, // Read strobe.
    input wire logic w8, // Device is 8 bits wide.
    output logic [15:0] ext_din // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lo;
    logic [15:0] last = 16'h0000;
    // Idle lanes show the inverse of the last value, so a stale sample never matches.
    always @(ext_rd_n or ext_addr or w8) begin
        lo = {ext_addr[7:1], ext_addr[0] & w8} ^ 8'h5A;
        if (!ext_rd_n) ext_din = w8 ? {~lo, lo} : {{ext_addr[7:1], 1'b1} ^ 8'h5A, lo};
        else ext_din = ~last;
        last = ext_din;
    end
endmodule
`default_nettype wire

// ### cswc_pkg.sv
// Package for the chip select and wait control block: register map, field positions,
// reset values, bus timing counts and the types that travel between the files.
// Assumes a single clock domain and an 8-bit register port.
`default_nettype none
package cswc_pkg;
    // Register indices on the plain register port.
    localparam logic [4:0] REG_SPC_BASE = 5'h00;
    localparam logic [4:0] REG_DEF = 5'h04;
    localparam logic [4:0] REG_START_BASE = 5'h08;
    localparam logic [4:0] REG_MASK_BASE = 5'h0C;
    localparam logic [4:0] REG_PORT_FN = 5'h10;
    localparam logic [4:0] REG_PORT_DIR = 5'h11;
    localparam logic [4:0] REG_STATUS = 5'h12;
    // Field positions inside a control register.
    localparam int BIT_EN = 7;
    localparam int BIT_AREA = 6;
    localparam int BIT_W8 = 3;
    localparam int WAIT_LSB = 0;
    // Values after reset.
    localparam logic [7:0] SPC_RST = 8'h00;
    localparam logic [7:0] SPC2_RST = 8'h80;
    localparam logic [7:0] DEF_RST = 8'h00;
    localparam logic [7:0] START_RST = 8'hFF;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [2:0] PORT_RST = 3'h0;
    // Wait field codes and the bus states each one inserts.
    localparam logic [2:0] WC_TWO = 3'h0;
    localparam logic [2:0] WC_ONE = 3'h1;
    localparam logic [2:0] WC_EXT = 3'h2;
    localparam logic [2:0] WC_ZERO = 3'h3;
    localparam logic [2:0] WC_THREE = 3'h5;
    localparam logic [2:0] WC_FOUR = 3'h6;
    localparam logic [2:0] WC_EIGHT = 3'h7;
    // Strobe cycles without waits, and cycles to let read data pass the pin synchroniser.
    localparam logic [3:0] STRB_BASE = 4'h1;
    localparam logic [3:0] SYNC_LAT = 4'h2;
    // Region code of the default region, and operand size codes.
    localparam logic [2:0] REGION_DEF = 3'h4;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;

    typedef struct packed {
        logic [23:0] addr;
        logic [1:0] size;
        logic write;
        logic [31:0] wdata;
    } cswc_req_t;

    typedef struct packed {
        logic lo_use;
        logic hi_use;
        logic [1:0] hi_idx;
        logic [2:0] nb;
        logic [3:0] waits;
        logic [3:0] cs;
    } cswc_piece_t;

    typedef enum logic [2:0] {ST_IDLE, ST_INT, ST_ADDR, ST_STRB, ST_HOLD} cswc_state_t;
endpackage
`default_nettype wire

// ### cswc_space_decode.sv
// Address decoder for the four programmable spaces of the chip select block.
// Assumes the register values come from flops on the same clock as the address.
`default_nettype none
module cswc_space_decode
    import cswc_pkg::*;
(
    input wire logic mclk, // Clock, used by the checks only.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [23:0] addr, // Byte address of the current bus piece.
    input wire logic [3:0][7:0] start, // Start address registers, bits 23..16.
    input wire logic [3:0][7:0] mask, // Address mask registers.
    input wire logic [3:0] en, // Master enables of the spaces.
    input wire logic area2, // Space 2 uses its window when set.
    output logic [2:0] region, // Winning space number, or the default region.
    output logic [3:0] cs_sel // One-hot select of the winning space.
);
    logic [3:0] hit;

    // Maps an 8-bit mask register onto address bits 23..8; spaces 0 and 1 each map other bits, spaces 2 and 3 share one map.
    function automatic logic [15:0] expand_mask(input int idx, input logic [7:0] m);
        logic [15:0] e;
        e = 16'h0000;
        if (idx == 0) begin
            e = {3'h0, m[7:2], {6{m[1]}}, m[0]};
        end else if (idx == 1) begin
            e = {2'h0, m[7:2], {7{m[1]}}, m[0]};
        end else begin
            e = {1'h0, m, 7'h7F};
        end
        return e;
    endfunction

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hit[i] = en[i] && (((addr[23:8] ^ {start[i], 8'h00}) & ~expand_mask(i, mask[i])) == 16'h0000);
        end
        if (en[2] && !area2) begin
            hit[2] = 1'b1;
        end
    end

    always_comb begin
        region = REGION_DEF;
        cs_sel = 4'h0;
        for (int i = 3; i >= 0; i--) begin
            if (hit[i]) begin
                region = 3'(i);
                cs_sel = 4'h1 << i;
            end
        end
    end

    // Space 0 overrides every other space when it matches.
    property p_prio;
        @(posedge mclk) disable iff (rst) hit[0] |-> (region == 3'h0) && (cs_sel == 4'h1);
    endproperty
    a_prio: assert property (p_prio) else $error("space 0 did not win priority");

    // A disabled space is never chosen.
    property p_enable;
        @(posedge mclk) disable iff (rst) (region != REGION_DEF) |-> en[region[1:0]];
    endproperty
    a_enable: assert property (p_enable) else $error("disabled space was selected");
endmodule
`default_nettype wire

// ### cswc_top.sv
// Chip select and wait control: decodes core accesses into spaces, splits operands for
// dynamic bus sizing and runs external bus cycles with programmed waits.
// Assumes core requests and the register port are on mclk; external data pins are async.
//
// Function
// - Bit 7 enables a space; its decode, width and waits apply only then.
// - Reset disables spaces 0, 1, 3 and enables space 2.
// - Bit 3 picks bus width per region: 0 is 16 bits, 1 is 8 bits.
// - 8-bit memory uses low lane; 16-bit uses low lane even, high lane odd.
// - Wide or misaligned operands split into cycles at ascending addresses.
// - Read data on lanes carrying no operand byte is ignored.
// - Unused write lanes float and their write strobe stays inactive.
// - Bits 2..0 set the wait states inserted for that region.
// - Wait codes map to 2, 1, 0, 3, 4 or 8 wait states.
// - The externally extended wait code acts as one wait.
// - Reset loads every wait field with the two-wait code.
// - Addresses outside all spaces use the default region settings.
// - Space 2 bit 6 chooses whole range or start and mask window.
// - Reset clears the space 2 area select, covering the whole range.
// - Space 3 has no pin but still applies its waits when enabled.
// - Spaces overlapping internal areas serve internally with no chip select.
// - A select pin drives only when port function and direction bits are set.
// - A space hits when unmasked address bits equal the start address.
// - The lowest-numbered matching space takes priority.
`default_nettype none
module cswc_top
    import cswc_pkg::*;
(
    input wire logic mclk, // System clock, 125 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [4:0] reg_addr, // Register index.
    input wire logic [7:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    output logic [7:0] reg_rdata, // Read data, valid the cycle after the strobe.
    input wire logic req_valid, // Core access request.
    input wire cswc_req_t req, // Core access: address, size, direction, data.
    input wire logic req_internal, // Access falls in an internal I/O, RAM or ROM area.
    output logic req_ready, // Request accepted while high.
    output logic done, // One-cycle pulse when the access completes.
    output logic [31:0] rd_data, // Assembled read operand.
    output logic [23:0] ext_addr, // External address bus.
    output logic [15:0] ext_dout, // External data out.
    output logic [1:0] ext_doe_n, // Data lane output enables, low while driving.
    input wire logic [15:0] ext_din, // External data in.
    output logic ext_rd_n, // Read strobe.
    output logic ext_wrl_n, // Low lane write strobe.
    output logic ext_wrh_n, // High lane write strobe.
    output logic [2:0] cs_pin_n // Chip select pins of spaces 0 to 2.
);
    cswc_state_t state_ff, nxt_state;
    cswc_req_t req_ff;
    cswc_piece_t pc_ff, nxt_pc;
    logic [3:0][7:0] spc_ctl_ff, start_ff, mask_ff;
    logic [3:0] def_ctl_ff;
    logic [2:0] port_fn_ff, port_dir_ff;
    logic [23:0] cur_addr_ff;
    logic [2:0] k_ff, left_ff;
    logic [3:0] cnt_ff;
    logic [3:0] cs_act_ff, nxt_cs_act;
    logic [2:0] region, last_region_ff;
    logic [3:0] cs_sel, dec_en;
    logic [2:0] dec_code;
    logic dec_w8;
    logic [15:0] din_s1_ff, din_s2_ff;
    logic [31:0] rbuf_ff;
    logic [7:0] reg_rdata_ff;
    logic done_ff, rd_n_ff, wrl_n_ff, wrh_n_ff;
    logic [1:0] doe_n_ff;
    logic [15:0] dout_ff;
    logic [23:0] ext_addr_ff;
    logic [2:0] cs_pin_n_ff;

    // Wait code to number of inserted bus states.
    function automatic logic [3:0] wait_decode(input logic [2:0] c);
        logic [3:0] w;
        w = 4'h2;
        case (c)
            WC_TWO: w = 4'h2;
            WC_ONE: w = 4'h1;
            WC_EXT: w = 4'h1;
            WC_ZERO: w = 4'h0;
            WC_THREE: w = 4'h3;
            WC_FOUR: w = 4'h4;
            WC_EIGHT: w = 4'h8;
            default: w = 4'h2; // Reserved code; software must not use it.
        endcase
        return w;
    endfunction

    // Picks byte i of a 32-bit operand.
    function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] i);
        return w[{i, 3'h0} +: 8];
    endfunction

    assign dec_en = {spc_ctl_ff[3][BIT_EN], spc_ctl_ff[2][BIT_EN], spc_ctl_ff[1][BIT_EN], spc_ctl_ff[0][BIT_EN]};

    cswc_space_decode u_dec (
        .mclk(mclk),
        .rst(rst),
        .addr(cur_addr_ff),
        .start(start_ff),
        .mask(mask_ff),
        .en(dec_en),
        .area2(spc_ctl_ff[2][BIT_AREA]),
        .region(region),
        .cs_sel(cs_sel)
    );

    always_comb begin
        if (region == REGION_DEF) begin
            dec_w8 = def_ctl_ff[BIT_W8];
            dec_code = def_ctl_ff[WAIT_LSB +: 3];
        end else begin
            dec_w8 = spc_ctl_ff[region[1:0]][BIT_W8];
            dec_code = spc_ctl_ff[region[1:0]][WAIT_LSB +: 3];
        end
    end

    always_comb begin
        nxt_pc = '0;
        nxt_pc.waits = wait_decode(dec_code);
        nxt_pc.cs = cs_sel;
        nxt_pc.hi_idx = k_ff[1:0];
        nxt_pc.nb = 3'h1;
        if (dec_w8) begin
            nxt_pc.lo_use = 1'b1;
        end else if (cur_addr_ff[0]) begin
            nxt_pc.hi_use = 1'b1;
        end else if (left_ff >= 3'h2) begin
            nxt_pc.lo_use = 1'b1;
            nxt_pc.hi_use = 1'b1;
            nxt_pc.hi_idx = k_ff[1:0] + 2'h1;
            nxt_pc.nb = 3'h2;
        end else begin
            nxt_pc.lo_use = 1'b1;
        end
    end

    // Sequencer: each piece is one address state, strobe states for the base plus waits, then a hold for the synchroniser.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_state = req_internal ? ST_INT : ST_ADDR;
                end
            end
            ST_INT: nxt_state = ST_IDLE;
            ST_ADDR: nxt_state = ST_STRB;
            ST_STRB: begin
                if (cnt_ff == 4'h0) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_ff == 4'h0) begin
                    nxt_state = (left_ff == pc_ff.nb) ? ST_IDLE : ST_ADDR;
                end
            end
        endcase
    end

    assign req_ready = (state_ff == ST_IDLE);

    // State, counters and operand position.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            req_ff <= '0;
            pc_ff <= '0;
            cur_addr_ff <= 24'h000000;
            k_ff <= 3'h0;
            left_ff <= 3'h0;
            cnt_ff <= 4'h0;
            last_region_ff <= REGION_DEF;
        end else begin
            state_ff <= nxt_state;
            unique case (state_ff)
                ST_IDLE: begin
                    if (req_valid) begin
                        req_ff <= req;
                        cur_addr_ff <= req.addr;
                        k_ff <= 3'h0;
                        left_ff <= (req.size == SZ_BYTE) ? 3'h1 : (req.size == SZ_WORD) ? 3'h2 : 3'h4;
                    end
                end
                ST_INT: cnt_ff <= 4'h0;
                ST_ADDR: begin
                    pc_ff <= nxt_pc;
                    last_region_ff <= region;
                    cnt_ff <= STRB_BASE + nxt_pc.waits - 4'h1;
                end
                ST_STRB: begin
                    cnt_ff <= (cnt_ff == 4'h0) ? SYNC_LAT - 4'h1 : cnt_ff - 4'h1;
                end
                ST_HOLD: begin
                    if (cnt_ff == 4'h0) begin
                        k_ff <= k_ff + pc_ff.nb;
                        left_ff <= left_ff - pc_ff.nb;
                        cur_addr_ff <= cur_addr_ff + 24'(pc_ff.nb);
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
            endcase
        end
    end

    // Chip select activity follows the piece from strobe start to hold end.
    always_comb begin
        nxt_cs_act = cs_act_ff;
        if (state_ff == ST_ADDR) begin
            nxt_cs_act = nxt_pc.cs;
        end else if (state_ff == ST_HOLD && cnt_ff == 4'h0) begin
            nxt_cs_act = 4'h0;
        end else if (state_ff == ST_IDLE || state_ff == ST_INT) begin
            nxt_cs_act = 4'h0;
        end
    end

    // External pins; strobes cover the base state plus every wait.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_act_ff <= 4'h0;
            cs_pin_n_ff <= 3'h7;
            ext_addr_ff <= 24'h000000;
            rd_n_ff <= 1'b1;
            wrl_n_ff <= 1'b1;
            wrh_n_ff <= 1'b1;
            doe_n_ff <= 2'h3;
            dout_ff <= 16'h0000;
        end else begin
            cs_act_ff <= nxt_cs_act;
            cs_pin_n_ff <= ~(nxt_cs_act[2:0] & port_fn_ff & port_dir_ff);
            if (state_ff == ST_ADDR) begin
                ext_addr_ff <= cur_addr_ff;
                rd_n_ff <= req_ff.write;
                wrl_n_ff <= !(req_ff.write && nxt_pc.lo_use);
                wrh_n_ff <= !(req_ff.write && nxt_pc.hi_use);
                doe_n_ff <= {!(req_ff.write && nxt_pc.hi_use), !(req_ff.write && nxt_pc.lo_use)};
                dout_ff <= {get_byte(req_ff.wdata, nxt_pc.hi_idx), get_byte(req_ff.wdata, k_ff[1:0])};
            end else if (state_ff == ST_STRB && cnt_ff == 4'h0) begin
                rd_n_ff <= 1'b1;
                wrl_n_ff <= 1'b1;
                wrh_n_ff <= 1'b1;
            end else if (state_ff == ST_HOLD && cnt_ff == 4'h0) begin
                doe_n_ff <= 2'h3;
            end
        end
    end

    // Read data pins pass two flops before anything looks at them.
    always_ff @(posedge mclk) begin
        if (rst) begin
            din_s1_ff <= 16'h0000;
            din_s2_ff <= 16'h0000;
        end else begin
            din_s1_ff <= ext_din;
            din_s2_ff <= din_s1_ff;
        end
    end

    // Operand assembly; the hold lasts just long enough for strobe-time data to arrive.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rbuf_ff <= 32'h00000000;
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == ST_INT) || (state_ff == ST_HOLD && cnt_ff == 4'h0 && left_ff == pc_ff.nb);
            if (state_ff == ST_IDLE && req_valid) begin
                rbuf_ff <= 32'h00000000;
            end else if (state_ff == ST_HOLD && cnt_ff == 4'h0 && !req_ff.write) begin
                if (pc_ff.lo_use) begin
                    rbuf_ff[{k_ff[1:0], 3'h0} +: 8] <= din_s2_ff[7:0];
                end
                if (pc_ff.hi_use) begin
                    rbuf_ff[{pc_ff.hi_idx, 3'h0} +: 8] <= din_s2_ff[15:8];
                end
            end
        end
    end

    // Register file; control registers are write-only so a read-modify-write cannot work.
    always_ff @(posedge mclk) begin
        if (rst) begin
            spc_ctl_ff <= {SPC_RST, SPC2_RST, SPC_RST, SPC_RST};
            def_ctl_ff <= DEF_RST[3:0];
            start_ff <= {4{START_RST}};
            mask_ff <= {4{MASK_RST}};
            port_fn_ff <= PORT_RST;
            port_dir_ff <= PORT_RST;
        end else if (reg_wr) begin
            if (reg_addr[4:2] == REG_SPC_BASE[4:2]) begin
                spc_ctl_ff[reg_addr[1:0]] <= reg_wdata;
            end
            if (reg_addr == REG_DEF) begin
                def_ctl_ff <= reg_wdata[3:0];
            end
            if (reg_addr[4:2] == REG_START_BASE[4:2]) begin
                start_ff[reg_addr[1:0]] <= reg_wdata;
            end
            if (reg_addr[4:2] == REG_MASK_BASE[4:2]) begin
                mask_ff[reg_addr[1:0]] <= reg_wdata;
            end
            if (reg_addr == REG_PORT_FN) begin
                port_fn_ff <= reg_wdata[2:0];
            end
            if (reg_addr == REG_PORT_DIR) begin
                port_dir_ff <= reg_wdata[2:0];
            end
        end
    end

    // Register reads; control registers and unmapped indices read as zero.
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= 8'h00;
            if (reg_addr[4:2] == REG_START_BASE[4:2]) begin
                reg_rdata_ff <= start_ff[reg_addr[1:0]];
            end
            if (reg_addr[4:2] == REG_MASK_BASE[4:2]) begin
                reg_rdata_ff <= mask_ff[reg_addr[1:0]];
            end
            if (reg_addr == REG_PORT_FN) begin
                reg_rdata_ff <= {5'h00, port_fn_ff};
            end
            if (reg_addr == REG_PORT_DIR) begin
                reg_rdata_ff <= {5'h00, port_dir_ff};
            end
            if (reg_addr == REG_STATUS) begin
                reg_rdata_ff <= {4'h0, !req_ready, last_region_ff};
            end
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign done = done_ff;
    assign rd_data = rbuf_ff;
    assign ext_addr = ext_addr_ff;
    assign ext_dout = dout_ff;
    assign ext_doe_n = doe_n_ff;
    assign ext_rd_n = rd_n_ff;
    assign ext_wrl_n = wrl_n_ff;
    assign ext_wrh_n = wrh_n_ff;
    assign cs_pin_n = cs_pin_n_ff;

    // Reset leaves only space 2 on, whole range, two waits everywhere.
    property p_reset_vals;
        @(posedge mclk) $past(rst) && !rst |-> spc_ctl_ff[2] == 8'h80 && spc_ctl_ff[0] == 8'h00
            && spc_ctl_ff[1] == 8'h00 && spc_ctl_ff[3] == 8'h00 && def_ctl_ff == 4'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong control values after reset");

    // Eight-wait code holds a read strobe for nine cycles.
    property p_eight;
        @(posedge mclk) disable iff (rst) (state_ff == ST_ADDR && dec_code == 3'h7 && !req_ff.write)
            |=> !ext_rd_n [*8] ##1 !ext_rd_n ##1 ext_rd_n;
    endproperty
    a_eight: assert property (p_eight) else $error("eight-wait strobe length wrong");

    // Zero-wait code gives a single strobe cycle; the external wait code gives two.
    property p_zero_ext;
        @(posedge mclk) disable iff (rst)
            (state_ff == ST_ADDR && !req_ff.write && dec_code == 3'h3 |=> !ext_rd_n ##1 ext_rd_n)
            and (state_ff == ST_ADDR && !req_ff.write && dec_code == 3'h2 |=> !ext_rd_n [*2] ##1 ext_rd_n);
    endproperty
    a_zero_ext: assert property (p_zero_ext) else $error("zero or extended wait handled wrong");

    // A write strobe on a lane implies that lane is driven.
    property p_lane;
        @(posedge mclk) disable iff (rst) (!ext_wrh_n |-> !ext_doe_n[1]) and (!ext_wrl_n |-> !ext_doe_n[0]);
    endproperty
    a_lane: assert property (p_lane) else $error("write strobe on floating lane");

    // An 8-bit region never uses the high lane.
    property p_w8;
        @(posedge mclk) disable iff (rst) (state_ff == ST_ADDR && dec_w8) |=> ext_wrh_n && ext_doe_n[1] && !pc_ff.hi_use;
    endproperty
    a_w8: assert property (p_w8) else $error("8-bit region used high lane");

    // A select pin is low only when its port bits were both set.
    property p_pin_gate;
        @(posedge mclk) disable iff (rst) (~cs_pin_n & ~($past(port_fn_ff) & $past(port_dir_ff))) == 3'h0;
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("select driven without port enable");

    // Internal accesses pulse done two cycles after being taken, without any select.
    property p_internal;
        @(posedge mclk) disable iff (rst) (state_ff == ST_IDLE && req_valid && req_internal)
            |=> (&cs_pin_n) ##1 (done && (&cs_pin_n));
    endproperty
    a_internal: assert property (p_internal) else $error("internal access drove a select");
endmodule
`default_nettype wire

// ### cswc_top_tb.sv
// Bench for the chip select block: registers, waits, sizing, lanes and selects.
// Assumes the memory model answers every read strobe at once.
`default_nettype none
module cswc_top_tb import cswc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0, req_internal = 0, w8 = 0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, hd;
    cswc_req_t req = '0;
    logic req_ready, done, ext_rd_n, ext_wrl_n, ext_wrh_n, wl, wh, dl, dh, csl;
    logic [31:0] rd_data;
    logic [23:0] ext_addr;
    logic [15:0] ext_dout, ext_din;
    logic [1:0] ext_doe_n;
    logic [2:0] cs_pin_n;
    int n_errors = 0, compares = 0, n;
    cswc_top cswc_top_i (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req_valid, .req,
        .req_internal, .req_ready, .done, .rd_data, .ext_addr, .ext_dout, .ext_doe_n, .ext_din, .ext_rd_n,
        .ext_wrl_n, .ext_wrh_n, .cs_pin_n);
    cswc_mem cswc_mem_i (.ext_addr, .ext_rd_n, .w8, .ext_din);
    initial forever #4 mclk = ~mclk;
    // Records lanes, write data and select seen during one access.
    always @(posedge mclk) begin
        if (!ext_wrl_n) wl <= 1;
        if (!ext_wrh_n) begin
            wh <= 1;
            hd <= ext_dout[15:8];
        end
        if (!ext_doe_n[0]) dl <= 1;
        if (!ext_doe_n[1]) dh <= 1;
        if (!cs_pin_n[2]) csl <= 1;
    end
    function automatic logic [7:0] f(input logic [23:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge mclk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge mclk);
        reg_rd <= 0;
        @(negedge mclk);
        chk("reg_rdata", e, reg_rdata);
    endtask
    // Counts cycles from the taking edge to the done pulse, bounded.
    task automatic acc(input logic [23:0] a, input logic [1:0] sz, input logic w);
        @(posedge mclk);
        {wl, wh, dl, dh, csl} = 5'h00;
        req_valid <= 1;
        req <= '{addr: a, size: sz, write: w, wdata: 32'h000000A5};
        @(posedge mclk);
        req_valid <= 0;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (done !== 1'b1 && n < 40);
    endtask
    task automatic t_reset;
        rd(5'h08, 8'hFF);
        rd(5'h02, 8'h00);
        rd(5'h1F, 8'h00);
        acc(24'h000020, SZ_BYTE, 0);
        chk("cycles", 7, n);
        chk("rd_data", f(24'h20), rd_data);
        $display("test reset done");
    endtask
    task automatic t_waits;
        logic [2:0] c [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
        int w [7] = '{2, 1, 1, 0, 3, 4, 8};
        for (int i = 0; i < 7; i++) begin
            wr(5'h02, {5'h10, c[i]});
            acc(24'h000022, SZ_BYTE, 0);
            chk("cycles", 5 + w[i], n);
        end
        $display("test waits done");
    endtask
    task automatic t_size;
        wr(5'h02, 8'h8B);
        w8 <= 1;
        acc(24'h000031, 2'h2, 0);
        chk("rd_data", {f(24'h34), f(24'h33), f(24'h32), f(24'h31)}, rd_data);
        chk("cycles", 17, n);
        wr(5'h02, 8'h83);
        w8 <= 0;
        acc(24'h000041, 2'h2, 0);
        chk("rd_data", {f(24'h44), f(24'h43), f(24'h42), f(24'h41)}, rd_data);
        chk("cycles", 13, n);
        acc(24'h000051, SZ_BYTE, 1);
        chk("lanes", 4'h5, {wl, wh, dl, dh});
        chk("high lane", 8'hA5, hd);
        $display("test sizing done");
    endtask
    task automatic t_cs;
        wr(5'h10, 8'h04);
        wr(5'h11, 8'h04);
        acc(24'h000060, SZ_BYTE, 0);
        chk("select", 1, csl);
        req_internal <= 1;
        acc(24'h000060, SZ_BYTE, 0);
        chk("cycles", 2, n);
        chk("select", 0, csl);
        req_internal <= 0;
        $display("test selects done");
    endtask
    task automatic t_space;
        wr(5'h02, 8'h80);
        wr(5'h08, 8'h00);
        wr(5'h0C, 8'h07);
        wr(5'h00, 8'h83);
        acc(24'h000010, SZ_BYTE, 0);
        chk("cycles", 5, n);
        acc(24'h010010, SZ_BYTE, 0);
        chk("cycles", 7, n);
        wr(5'h00, 8'h03);
        acc(24'h000010, SZ_BYTE, 0);
        chk("cycles", 7, n);
        wr(5'h0B, 8'h01);
        wr(5'h0F, 8'h01);
        wr(5'h03, 8'h87);
        wr(5'h02, 8'hC0);
        acc(24'h010010, SZ_BYTE, 0);
        chk("cycles", 13, n);
        wr(5'h02, 8'h00);
        wr(5'h04, 8'h0B);
        w8 <= 1;
        acc(24'h000061, SZ_BYTE, 0);
        chk("cycles", 5, n);
        chk("rd_data", f(24'h61), rd_data);
        $display("test spaces done");
    endtask
    task automatic summarize;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 0;
        t_reset;
        t_waits;
        t_size;
        t_cs;
        t_space;
        summarize;
    end
    // Cuts a hang short; the whole run needs well under a thousand cycles.
    initial begin
        repeat (3000) @(posedge mclk);
        n_errors++;
        summarize;
    end
endmodule
`default_nettype wire
